// ===== dv/fcsd_flash_model.sv
/* Behavioural x16 NOR flash for the controller bench: unlock decode, lock and
   correction overlays, array data. Assumes one controller drives its strobes. */
`timescale 1ns/1ps
module fcsd_flash_model
  import fcsd_pkg::*;
(
  // Flash pins
  input  wire logic [FCSD_ADDR_W-1:0] addr_i,
  input  wire logic                   ce_n_i,
  input  wire logic                   we_n_i,
  input  wire logic                   oe_n_i,
  input  wire logic [FCSD_DATA_W-1:0] dq_i,
  output logic [FCSD_DATA_W-1:0]      dq_o,
  // Bench view
  output logic [7:0]                  n_wr_o
);
  fcsd_mode_t  mode_reg = FCSD_MODE_ARRAY;  // Active overlay
  logic [1:0]  step_reg = 2'd0;             // Unlock progress
  logic        prog_reg = 1'b0;             // A0 seen, lock data next
  logic        exit_reg = 1'b0;             // First exit word seen
  logic        lock_reg [1024];             // Protected flag per sector
  logic [15:0] last_reg = 16'h0;            // Last word put on the bus
  logic [15:0] rd_w;
  logic [7:0]  c_w;
  logic [10:0] a_w;
  initial begin
    n_wr_o = 8'h00;
    foreach (lock_reg[i]) lock_reg[i] = 1'b0;
  end
  assign c_w = dq_i[7:0];
  assign a_w = addr_i[10:0];
  // Read data by overlay
  always_comb begin
    case (mode_reg)
      FCSD_MODE_VLOCK: rd_w = lock_reg[addr_i[25:16]] ? 16'h0000 : 16'h0001;
      FCSD_MODE_ECC:   rd_w = {15'h0, ^addr_i[3:0]};
      default:         rd_w = addr_i[15:0] ^ 16'h3c3c;
    endcase
  end
  // Released bus shows the inverse so a stale sample cannot pass
  assign dq_o = (!ce_n_i && !oe_n_i) ? rd_w : ~last_reg;
  always @(negedge oe_n_i) begin
    #8 last_reg <= rd_w;
  end
  // Write cycles are sampled 8 ns into the strobe, away from the pin update edge
  always @(negedge we_n_i) begin
    #8;
    if (!ce_n_i) begin
      n_wr_o <= n_wr_o + 8'h01;
      exit_reg <= 1'b0;
      if (prog_reg) begin
        prog_reg <= 1'b0;
        if (c_w == FCSD_LOCK_SET || c_w == FCSD_LOCK_CLR) lock_reg[addr_i[25:16]] <= (c_w == FCSD_LOCK_SET);
      end else if (c_w == FCSD_CMD_RESET) begin
        mode_reg <= FCSD_MODE_ARRAY;
        step_reg <= 2'd0;
      end else if (c_w == FCSD_CMD_EXIT1 && mode_reg != FCSD_MODE_ARRAY) exit_reg <= 1'b1;
      else if (exit_reg && c_w == FCSD_CMD_EXIT2) mode_reg <= FCSD_MODE_ARRAY;
      else if (mode_reg == FCSD_MODE_VLOCK && c_w == FCSD_CMD_PROG) prog_reg <= 1'b1;
      else if (step_reg == 2'd0 && a_w == 11'h555 && c_w == FCSD_CODE_AA) step_reg <= 2'd1;
      else if (step_reg == 2'd1 && a_w == 11'h2aa && c_w == FCSD_CODE_55) step_reg <= 2'd2;
      // No erase, suspend, lock register or password state is held here: such commands
      // land in this branch and are ignored, as they are when no matching operation runs
      else begin
        if (step_reg == 2'd2 && a_w == 11'h555 && c_w == FCSD_CMD_VLOCK) mode_reg <= FCSD_MODE_VLOCK;
        if (step_reg == 2'd2 && a_w == 11'h555 && c_w == FCSD_CMD_ECC) mode_reg <= FCSD_MODE_ECC;
        step_reg <= 2'd0;
      end
    end
  end
endmodule : fcsd_flash_model

// ===== dv/test_fcsd_ctrl.sv
/* Bench for the flash command-sequence controller: register port driver with
   queued read checks, behavioural flash on the pins. Assumes a single clock. */
`timescale 1ns/1ps
module test_fcsd_ctrl
  import fcsd_pkg::*;
;
  logic                   clk_i = 1'b0;
  logic                   rst_i = 1'b1;
  logic                   reg_wr_i = 1'b0;
  logic                   reg_rd_i = 1'b0;
  logic                   rd_d = 1'b0;      // Read strobe of the last cycle
  logic [3:0]             reg_addr_i = 4'h0;
  logic [31:0]            reg_wdata_i = 32'h0;
  logic [31:0]            reg_rdata_o;
  logic [31:0]            poll_v = 32'h0;   // Last status seen by polling
  logic [FCSD_ADDR_W-1:0] fl_addr_o;
  logic                   fl_ce_n_o;
  logic                   fl_we_n_o;
  logic                   fl_oe_n_o;
  logic                   fl_dq_oe_o;
  logic [FCSD_DATA_W-1:0] fl_dq_o;
  logic [FCSD_DATA_W-1:0] fl_dq_i;
  logic [7:0]             n_wr;
  logic [7:0]             w;
  logic [25:0]            a;
  logic [25:0]            s;
  logic [32:0]            e;
  logic [32:0]            exp_q [$];        // Bit 32 marks a poll with no expectation
  int                     n_mismatch = 0;
  int                     comparisons = 0;
  always #2 clk_i = ~clk_i;
  fcsd_ctrl u_dut (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .fl_addr_o(fl_addr_o),
    .fl_ce_n_o(fl_ce_n_o), .fl_we_n_o(fl_we_n_o), .fl_oe_n_o(fl_oe_n_o), .fl_dq_o(fl_dq_o),
    .fl_dq_oe_o(fl_dq_oe_o), .fl_dq_i(fl_dq_i));
  fcsd_flash_model u_flash (.addr_i(fl_addr_o), .ce_n_i(fl_ce_n_o), .we_n_i(fl_we_n_o),
    .oe_n_i(fl_oe_n_o), .dq_i(fl_dq_o), .dq_o(fl_dq_i), .n_wr_o(n_wr));
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check
  // Read data stand only in the cycle after the strobe
  always @(posedge clk_i) begin
    rd_d <= reg_rd_i;
    if (rd_d) begin
      e = exp_q.pop_front();
      poll_v = reg_rdata_o;
      if (!e[32]) check(reg_rdata_o, e[31:0]);
    end
  end
  // One port cycle; strobes stay up only if the next call keeps them
  task automatic cyc(input logic wr, input logic rd, input logic [3:0] ad, input logic [31:0] d,
                     input logic [32:0] x);
    @(posedge clk_i);
    reg_wr_i <= wr;
    reg_rd_i <= rd;
    reg_addr_i <= ad;
    reg_wdata_i <= d;
    if (rd) exp_q.push_back(x);
  endtask : cyc
  task automatic idle();
    cyc(1'b0, 1'b0, 4'h0, 32'h0, 33'h0);
  endtask : idle
  task automatic rd(input logic [3:0] ad, input logic [31:0] want);
    cyc(1'b0, 1'b1, ad, 32'h0, {1'b0, want});
    idle();
  endtask : rd
  // Start an operation and poll busy under a bound
  task automatic run_op(input fcsd_op_t op, input logic [25:0] ad);
    int k;
    cyc(1'b1, 1'b0, FCSD_REG_ADDR, {6'h0, ad}, 33'h0);
    cyc(1'b1, 1'b0, FCSD_REG_CTRL, {28'h0, op}, 33'h0);
    k = 0;
    do begin
      idle();
      cyc(1'b0, 1'b1, FCSD_REG_CTRL, 32'h0, {1'b1, 32'h0});
      idle();
      idle();
      // The monitor fills poll_v on the edge just passed; test it one edge later, clear of that race
      idle();
      k++;
    end while (poll_v[FCSD_STAT_BUSY] !== 1'b0 && k < 500);
    if (k >= 500) n_mismatch++;
  endtask : run_op
  function automatic logic [31:0] arr(input logic [25:0] ad);
    return {16'h0, ad[15:0] ^ 16'h3c3c};
  endfunction : arr
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  // Whole run is under a thousand cycles; this bound of 40000 cycles is far beyond it
  initial begin
    #160000;
    n_mismatch++;
    print_verdict();
  end
  initial begin
    void'($urandom(96493));
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(FCSD_REG_MODE, 32'h0);
    rd(FCSD_REG_CTRL, 32'h0);
    rd(4'hf, 32'h0);
    repeat (3) begin
      a = 26'($urandom);
      run_op(FCSD_OP_READ, a);
      rd(FCSD_REG_RDATA, arr(a));
    end
    // Lock ops are refused outside the overlay; entry is three writes
    w = n_wr;
    run_op(FCSD_OP_VL_SET, a);
    run_op(FCSD_OP_VL_ENTER, a);
    check({24'h0, n_wr - w}, 32'h3);
    rd(FCSD_REG_MODE, 32'h1);
    s = {a[25:16], 16'h0};
    run_op(FCSD_OP_VL_STATUS, s | 26'($urandom & 32'hffff));
    rd(FCSD_REG_RDATA, 32'h1);
    run_op(FCSD_OP_VL_SET, s | 26'h0ffff);
    run_op(FCSD_OP_VL_STATUS, s | 26'h00123);
    rd(FCSD_REG_CTRL, 32'h2);
    rd(FCSD_REG_RDATA, 32'h0);
    run_op(FCSD_OP_VL_STATUS, s ^ 26'h10000);
    rd(FCSD_REG_RDATA, 32'h1);
    run_op(FCSD_OP_ECC_ENTER, a);
    rd(FCSD_REG_MODE, 32'h1);
    run_op(FCSD_OP_VL_CLEAR, s | 26'h0abcd);
    run_op(FCSD_OP_VL_STATUS, s);
    rd(FCSD_REG_RDATA, 32'h1);
    run_op(FCSD_OP_EXIT, a);
    rd(FCSD_REG_MODE, 32'h0);
    run_op(FCSD_OP_READ, a);
    rd(FCSD_REG_RDATA, arr(a));
    // Correction status overlay, left by the single reset word
    run_op(FCSD_OP_ECC_ENTER, a);
    rd(FCSD_REG_MODE, 32'h2);
    run_op(FCSD_OP_READ, a);
    rd(FCSD_REG_RDATA, {31'h0, ^a[3:0]});
    run_op(FCSD_OP_RESET, a);
    rd(FCSD_REG_MODE, 32'h0);
    run_op(FCSD_OP_READ, a ^ 26'h00055);
    rd(FCSD_REG_RDATA, arr(a ^ 26'h00055));
    print_verdict();
  end
endmodule : test_fcsd_ctrl

// ===== src/fcsd_bus_cycle.sv
/*
  One asynchronous flash bus cycle: drives address, chip enable, write or
  output enable and data for the strobe time, then recovers.
  Assumes the flash meets its access time within the strobe time.
*/
`timescale 1ns/1ps
module fcsd_bus_cycle
  import fcsd_pkg::*;
(
  // Clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  // Request side
  input  wire logic                   start_i,
  input  wire logic                   write_i,
  input  wire logic [FCSD_ADDR_W-1:0] addr_i,
  input  wire logic [FCSD_DATA_W-1:0] wdata_i,
  output logic                        ready_o,
  output logic                        done_o,
  output logic [FCSD_DATA_W-1:0]      rdata_o,
  // Flash pins
  output logic [FCSD_ADDR_W-1:0]      fl_addr_o,
  output logic                        fl_ce_n_o,
  output logic                        fl_we_n_o,
  output logic                        fl_oe_n_o,
  output logic [FCSD_DATA_W-1:0]      fl_dq_o,
  output logic                        fl_dq_oe_o,
  input  wire logic [FCSD_DATA_W-1:0] fl_dq_i
);
  typedef enum logic [1:0] {FCSD_BC_IDLE, FCSD_BC_STROBE, FCSD_BC_RECOV} fcsd_bc_state_t;

  fcsd_bc_state_t state_reg;   // Cycle phase
  logic [7:0]     cnt_reg;     // Phase timer
  logic           write_reg;   // Cycle direction

  assign ready_o = (state_reg == FCSD_BC_IDLE);

  // Phase sequencing; recovery keeps consecutive cycles from merging on the strobes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= FCSD_BC_IDLE;
      cnt_reg   <= 8'h00;
      done_o    <= 1'b0;
    end else begin
      done_o <= 1'b0;
      case (state_reg)
        FCSD_BC_IDLE: begin
          if (start_i) begin
            state_reg <= FCSD_BC_STROBE;
            cnt_reg   <= 8'(FCSD_STROBE_CYC - 1);
          end
        end
        FCSD_BC_STROBE: begin
          if (cnt_reg == 8'h00) begin
            state_reg <= FCSD_BC_RECOV;
            cnt_reg   <= 8'(FCSD_RECOV_CYC - 1);
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        FCSD_BC_RECOV: begin
          if (cnt_reg == 8'h00) begin
            state_reg <= FCSD_BC_IDLE;
            done_o    <= 1'b1;
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        default: state_reg <= FCSD_BC_IDLE;
      endcase
    end
  end

  // Pin drive; strobes are registered so they never glitch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fl_addr_o  <= '0;
      fl_dq_o    <= '0;
      fl_ce_n_o  <= 1'b1;
      fl_we_n_o  <= 1'b1;
      fl_oe_n_o  <= 1'b1;
      fl_dq_oe_o <= 1'b0;
      write_reg  <= 1'b0;
    end else if (state_reg == FCSD_BC_IDLE && start_i) begin
      fl_addr_o  <= addr_i;
      fl_dq_o    <= wdata_i;
      write_reg  <= write_i;
      fl_ce_n_o  <= 1'b0;
      fl_we_n_o  <= ~write_i;
      fl_oe_n_o  <= write_i;
      fl_dq_oe_o <= write_i;
    end else if (state_reg == FCSD_BC_STROBE && cnt_reg == 8'h00) begin
      fl_ce_n_o  <= 1'b1;
      fl_we_n_o  <= 1'b1;
      fl_oe_n_o  <= 1'b1;
      fl_dq_oe_o <= 1'b0;
    end
  end

  // Read data captured on the last strobe cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= '0;
    end else if (state_reg == FCSD_BC_STROBE && cnt_reg == 8'h00 && !write_reg) begin
      rdata_o <= fl_dq_i;
    end
  end
endmodule : fcsd_bus_cycle

// ===== src/fcsd_ctrl.sv
/*
  Host-side command-sequence controller for a parallel NOR flash. Software
  starts an operation through a small register port; the controller issues the
  unlock, command and data cycles on the flash pins and tracks the overlay.
  Assumes software writes one operation at a time and polls busy.
*/
`timescale 1ns/1ps
module fcsd_ctrl
  import fcsd_pkg::*;
(
  // Clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  // Software register port
  input  wire logic [3:0]             reg_addr_i,
  input  wire logic [31:0]            reg_wdata_i,
  input  wire logic                   reg_wr_i,
  input  wire logic                   reg_rd_i,
  output logic [31:0]                 reg_rdata_o,
  // Flash pins
  output logic [FCSD_ADDR_W-1:0]      fl_addr_o,
  output logic                        fl_ce_n_o,
  output logic                        fl_we_n_o,
  output logic                        fl_oe_n_o,
  output logic [FCSD_DATA_W-1:0]      fl_dq_o,
  output logic                        fl_dq_oe_o,
  input  wire logic [FCSD_DATA_W-1:0] fl_dq_i
);
  // Sequencer states
  typedef enum logic [1:0] {FCSD_IDLE, FCSD_ISSUE, FCSD_WAIT} fcsd_state_t;

  fcsd_state_t            state_reg;    // Sequencer state
  fcsd_op_t               op_reg;       // Operation in progress
  fcsd_mode_t             mode_reg;     // Overlay the device is in
  logic [2:0]             step_reg;     // Cycle index within sequence
  logic [FCSD_ADDR_W-1:0] addr_reg;     // Target address
  logic [FCSD_DATA_W-1:0] wdata_reg;    // Program data
  logic [FCSD_DATA_W-1:0] rdata_reg;    // Last read result
  logic                   prot_reg;     // Last lock status was protected
  logic                   busy;         // Operation running

  // Current cycle presented to the bus engine
  logic                   cyc_write;    // Cycle is a write
  logic [FCSD_ADDR_W-1:0] cyc_addr;     // Cycle address
  logic [FCSD_DATA_W-1:0] cyc_data;     // Cycle data
  logic [2:0]             cyc_last;     // Index of final cycle
  logic                   bc_ready;     // Bus engine idle
  logic                   bc_done;      // Bus cycle finished
  logic [FCSD_DATA_W-1:0] bc_rdata;     // Bus read data
  logic                   start_ok;     // Software start is legal now
  logic [FCSD_ADDR_W-1:0] sect_addr;    // Sector-aligned address

  assign busy = (state_reg != FCSD_IDLE);
  // Low bits are don't-care to the device; aligning them keeps traces readable
  assign sect_addr = {addr_reg[FCSD_ADDR_W-1:FCSD_SECT_LSB], {FCSD_SECT_LSB{1'b0}}};

  // Start legality: overlay commands only where they make sense
  always_comb begin
    case (fcsd_op_t'(reg_wdata_i[FCSD_CTRL_OP_LSB +: 4]))
      FCSD_OP_READ:      start_ok = 1'b1;
      FCSD_OP_VL_ENTER:  start_ok = (mode_reg == FCSD_MODE_ARRAY);
      FCSD_OP_ECC_ENTER: start_ok = (mode_reg == FCSD_MODE_ARRAY);
      FCSD_OP_VL_SET:    start_ok = (mode_reg == FCSD_MODE_VLOCK);
      FCSD_OP_VL_CLEAR:  start_ok = (mode_reg == FCSD_MODE_VLOCK);
      FCSD_OP_VL_STATUS: start_ok = (mode_reg == FCSD_MODE_VLOCK);
      FCSD_OP_EXIT:      start_ok = (mode_reg == FCSD_MODE_VLOCK);
      FCSD_OP_RESET:     start_ok = 1'b1;
      // No buffered program, abort reset or password op is offered, so the host never
      // issues a shortened abort, a bad word count, a split line or out-of-order words
      default:           start_ok = 1'b0;
    endcase
  end

  // Cycle table per operation and step
  always_comb begin
    cyc_write = 1'b1;
    cyc_addr  = '0;
    cyc_data  = '0;
    cyc_last  = 3'd0;
    case (op_reg)
      FCSD_OP_READ: begin
        cyc_write = 1'b0;
        cyc_addr  = addr_reg;
      end
      FCSD_OP_VL_ENTER, FCSD_OP_ECC_ENTER: begin
        cyc_last = 3'd2;
        // Upper bits left zero in unlock cycles
        case (step_reg)
          3'd0: begin
            cyc_addr = FCSD_UNLOCK_A1;
            cyc_data = {8'h00, FCSD_CODE_AA};
          end
          3'd1: begin
            cyc_addr = FCSD_UNLOCK_A2;
            cyc_data = {8'h00, FCSD_CODE_55};
          end
          default: begin
            cyc_addr = FCSD_UNLOCK_A1;
            cyc_data = (op_reg == FCSD_OP_ECC_ENTER) ? {8'h00, FCSD_CMD_ECC}
                                                     : {8'h00, FCSD_CMD_VLOCK};
          end
        endcase
      end
      FCSD_OP_VL_SET, FCSD_OP_VL_CLEAR: begin
        cyc_last = 3'd1;
        if (step_reg == 3'd0) begin
          cyc_data = {8'h00, FCSD_CMD_PROG};
        end else begin
          cyc_addr = sect_addr;
          cyc_data = (op_reg == FCSD_OP_VL_SET) ? {8'h00, FCSD_LOCK_SET}
                                                : {8'h00, FCSD_LOCK_CLR};
        end
      end
      FCSD_OP_VL_STATUS: begin
        cyc_write = 1'b0;
        cyc_addr  = sect_addr;
      end
      FCSD_OP_EXIT: begin
        cyc_last = 3'd1;
        cyc_data = (step_reg == 3'd0) ? {8'h00, FCSD_CMD_EXIT1} : {8'h00, FCSD_CMD_EXIT2};
      end
      FCSD_OP_RESET: begin
        cyc_data = {8'h00, FCSD_CMD_RESET};
      end
      default: begin
        cyc_last = 3'd0;
      end
    endcase
  end

  // Sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= FCSD_IDLE;
      op_reg    <= FCSD_OP_READ;
      step_reg  <= 3'd0;
      addr_reg  <= '0;
      wdata_reg <= '0;
    end else begin
      case (state_reg)
        FCSD_IDLE: begin
          if (reg_wr_i && reg_addr_i == FCSD_REG_ADDR) begin
            addr_reg <= reg_wdata_i[FCSD_ADDR_W-1:0];
          end
          if (reg_wr_i && reg_addr_i == FCSD_REG_WDATA) begin
            wdata_reg <= reg_wdata_i[FCSD_DATA_W-1:0];
          end
          // Illegal starts are dropped silently; software sees busy stay low
          if (reg_wr_i && reg_addr_i == FCSD_REG_CTRL && start_ok) begin
            op_reg    <= fcsd_op_t'(reg_wdata_i[FCSD_CTRL_OP_LSB +: 4]);
            step_reg  <= 3'd0;
            state_reg <= FCSD_ISSUE;
          end
        end
        FCSD_ISSUE: begin
          if (bc_ready) begin
            state_reg <= FCSD_WAIT;
          end
        end
        FCSD_WAIT: begin
          if (bc_done) begin
            if (step_reg == cyc_last) begin
              state_reg <= FCSD_IDLE;
            end else begin
              step_reg  <= step_reg + 3'd1;
              state_reg <= FCSD_ISSUE;
            end
          end
        end
        default: state_reg <= FCSD_IDLE;
      endcase
    end
  end

  // Overlay tracking: entries open, exit and reset return to array reads
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_reg <= FCSD_MODE_ARRAY;
    end else if (state_reg == FCSD_WAIT && bc_done && step_reg == cyc_last) begin
      case (op_reg)
        FCSD_OP_VL_ENTER:  mode_reg <= FCSD_MODE_VLOCK;
        FCSD_OP_ECC_ENTER: mode_reg <= FCSD_MODE_ECC;
        FCSD_OP_EXIT:      mode_reg <= FCSD_MODE_ARRAY;
        FCSD_OP_RESET:     mode_reg <= FCSD_MODE_ARRAY;
        default:           mode_reg <= mode_reg;
      endcase
    end
  end

  // Read results; lock status is protected when the low byte is 00h
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_reg <= '0;
      prot_reg  <= 1'b0;
    end else if (state_reg == FCSD_WAIT && bc_done && !cyc_write) begin
      rdata_reg <= bc_rdata;
      if (op_reg == FCSD_OP_VL_STATUS) begin
        prot_reg <= (bc_rdata[7:0] == FCSD_LOCK_SET);
      end
    end
  end

  // Register read port, one cycle latency
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        FCSD_REG_CTRL:  reg_rdata_o <= {30'h0, prot_reg, busy};
        FCSD_REG_ADDR:  reg_rdata_o <= {6'h00, addr_reg};
        FCSD_REG_WDATA: reg_rdata_o <= {16'h0000, wdata_reg};
        FCSD_REG_RDATA: reg_rdata_o <= {16'h0000, rdata_reg};
        FCSD_REG_MODE:  reg_rdata_o <= {30'h0, mode_reg};
        default:        reg_rdata_o <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata_o <= 32'h0000_0000;
    end
  end

  // Single bus cycle engine
  fcsd_bus_cycle u_bus (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .start_i    (state_reg == FCSD_ISSUE),
    .write_i    (cyc_write),
    .addr_i     (cyc_addr),
    .wdata_i    (cyc_data),
    .ready_o    (bc_ready),
    .done_o     (bc_done),
    .rdata_o    (bc_rdata),
    .fl_addr_o  (fl_addr_o),
    .fl_ce_n_o  (fl_ce_n_o),
    .fl_we_n_o  (fl_we_n_o),
    .fl_oe_n_o  (fl_oe_n_o),
    .fl_dq_o    (fl_dq_o),
    .fl_dq_oe_o (fl_dq_oe_o),
    .fl_dq_i    (fl_dq_i)
  );

  // Checks
  cmd_upper_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!fl_we_n_o) |-> (fl_dq_o[15:8] == 8'h00))
    else $error("Upper byte not zero in command cycle");
  unlock_high_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!fl_we_n_o && fl_dq_o[7:0] == FCSD_CODE_AA) |-> (fl_addr_o == FCSD_UNLOCK_A1))
    else $error("Unlock cycle address wrong");
  write_has_data_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!fl_we_n_o) |-> (fl_dq_oe_o && fl_oe_n_o && !fl_ce_n_o))
    else $error("Write cycle without data drive");
  read_no_drive_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!fl_oe_n_o) |-> (!fl_dq_oe_o && fl_we_n_o))
    else $error("Read cycle drives data");
  exit_mode_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == FCSD_WAIT && bc_done && step_reg == cyc_last && op_reg == FCSD_OP_EXIT)
      |=> (mode_reg == FCSD_MODE_ARRAY))
    else $error("Exit did not return to array mode");
  reset_mode_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == FCSD_WAIT && bc_done && op_reg == FCSD_OP_RESET) |=> (mode_reg == FCSD_MODE_ARRAY))
    else $error("Reset did not return to array mode");
  lock_data_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!fl_we_n_o && op_reg == FCSD_OP_VL_CLEAR && step_reg == 3'd1) |-> (fl_dq_o[7:0] == FCSD_LOCK_CLR))
    else $error("Lock clear data wrong");
  sect_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!fl_we_n_o && op_reg == FCSD_OP_VL_SET && step_reg == 3'd1) |-> (fl_addr_o[15:0] == 16'h0000))
    else $error("Sector address low bits not aligned");
  ecc_entry_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == FCSD_WAIT && bc_done && step_reg == 3'd2 && op_reg == FCSD_OP_ECC_ENTER)
      |=> (mode_reg == FCSD_MODE_ECC))
    else $error("Correction overlay not entered");
  cover_ecc_c:   cover property (@(posedge clk_i) mode_reg == FCSD_MODE_ECC);
  cover_vlock_c: cover property (@(posedge clk_i) op_reg == FCSD_OP_VL_SET && bc_done);
  cover_stat_c:  cover property (@(posedge clk_i) prot_reg);
endmodule : fcsd_ctrl

// ===== src/fcsd_pkg.sv
/*
  Package for the flash command-sequence controller: bus codes, unlock addresses,
  command bytes, register offsets of the controller's own software port, field
  positions and bus timing counts.
  Assumes a x16 asynchronous parallel NOR flash on the far side of the pins.
*/
package fcsd_pkg;
  // Flash bus widths
  localparam int FCSD_ADDR_W      = 26;                 // Word address width
  localparam int FCSD_DATA_W      = 16;                 // x16 data bus
  localparam int FCSD_SECT_LSB    = 16;                 // Lowest sector select bit
  localparam int FCSD_DONTCARE_LSB = 11;                // Lowest ignored bit in unlock cycles

  // Unlock and command codes
  localparam logic [25:0] FCSD_UNLOCK_A1 = 26'h0000555;
  localparam logic [25:0] FCSD_UNLOCK_A2 = 26'h00002aa;
  localparam logic [7:0]  FCSD_CODE_AA   = 8'haa;
  localparam logic [7:0]  FCSD_CODE_55   = 8'h55;
  localparam logic [7:0]  FCSD_CMD_VLOCK = 8'he0;       // Volatile lock overlay entry
  localparam logic [7:0]  FCSD_CMD_ECC   = 8'h75;       // Correction status overlay entry
  localparam logic [7:0]  FCSD_CMD_PROG  = 8'ha0;       // Program / lock set-clear
  localparam logic [7:0]  FCSD_CMD_EXIT1 = 8'h90;       // Two-cycle exit, first word
  localparam logic [7:0]  FCSD_CMD_EXIT2 = 8'h00;       // Two-cycle exit, second word
  localparam logic [7:0]  FCSD_CMD_RESET = 8'hf0;       // Reset / overlay exit
  localparam logic [7:0]  FCSD_LOCK_SET  = 8'h00;       // Protected state / set data
  localparam logic [7:0]  FCSD_LOCK_CLR  = 8'h01;       // Unprotected state / clear data

  // Software port register offsets
  localparam logic [3:0] FCSD_REG_CTRL   = 4'h0;        // W: op start; R: status
  localparam logic [3:0] FCSD_REG_ADDR   = 4'h1;        // Target word address
  localparam logic [3:0] FCSD_REG_WDATA  = 4'h2;        // Program data
  localparam logic [3:0] FCSD_REG_RDATA  = 4'h3;        // Last read data
  localparam logic [3:0] FCSD_REG_MODE   = 4'h4;        // Overlay mode, read only

  // Control field positions
  localparam int FCSD_CTRL_OP_LSB = 0;                  // Operation code bits 3:0
  localparam int FCSD_STAT_BUSY   = 0;                  // Status busy bit
  localparam int FCSD_STAT_PROT   = 1;                  // Last lock status protected

  // Timing: strobe low 70 ns, recovery 20 ns, rounded up to whole clocks
  localparam int FCSD_CLK_NS      = 4;
  localparam int FCSD_STROBE_NS   = 70;
  localparam int FCSD_STROBE_CYC  = (FCSD_STROBE_NS + FCSD_CLK_NS - 1) / FCSD_CLK_NS;
  localparam int FCSD_RECOV_NS    = 20;
  localparam int FCSD_RECOV_CYC   = (FCSD_RECOV_NS + FCSD_CLK_NS - 1) / FCSD_CLK_NS;

  // Software operations
  typedef enum logic [3:0] {
    FCSD_OP_READ      = 4'h1,  // Plain array read
    FCSD_OP_VL_ENTER  = 4'h2,  // Enter volatile lock overlay
    FCSD_OP_VL_SET    = 4'h3,  // Set volatile lock on sector
    FCSD_OP_VL_CLEAR  = 4'h4,  // Clear volatile lock on sector
    FCSD_OP_VL_STATUS = 4'h5,  // Read sector lock status
    FCSD_OP_ECC_ENTER = 4'h6,  // Enter correction status overlay
    FCSD_OP_EXIT      = 4'h7,  // Two-cycle exit
    FCSD_OP_RESET     = 4'h8   // Single-cycle reset / overlay exit
  } fcsd_op_t;

  // Overlay the device is known to be in
  typedef enum logic [1:0] {
    FCSD_MODE_ARRAY,
    FCSD_MODE_VLOCK,
    FCSD_MODE_ECC
  } fcsd_mode_t;
endpackage : fcsd_pkg
